// File: rtl/acc_pkg.sv
// How it works
// - enable powers converter; clearing aborts conversion
// - single mode: each start write with enable set while idle, one conversion
// - free running: start launches, then self-repeats
// - first conversion 25 cycles, later ones 13
// - start reads one while busy; zero ignored
// - auto trigger: rising edge of chosen source
// - flag sets on every completion, even while the lock holds the result
// - irq only with flag, enable, global enable
// - flag cleared by vector or writing one
// - prescaler codes give divide 2,2,4..128
// - left adjust 15:6, else 9:0 zero-filled
// - differential channels give two's complement result
// - low byte read locks result until high
// - source field ignored without auto trigger
// - source codes: free, comparator, int0, timers
// - selection switch to set source triggers
// - switching to free running never triggers
// - disable bit kills buffer, pin reads zero
// - channel and reference change after completion
// - left adjust changes presentation at once

package acc_pkg;

  // ----------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------
  localparam logic [7:0] IDX_RESULT_LOW = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h7a;
  localparam logic [7:0] IDX_TRIG_SELECT = 8'h7b;
  localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h7c;
  localparam logic [7:0] IDX_PIN_DISABLE = 8'h7e;

  // ----------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [2:0] RST_TRIG_SELECT = 3'h0;
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] RST_PIN_DISABLE = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam int LEFT_PAD = 6;           // zero bits below a left adjusted result
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [4:0] DIFF_FIRST = 5'h08;   // first differential channel code
  localparam logic [4:0] DIFF_LAST = 5'h1d;    // last differential channel code

  // ----------------------------------------------------------
  // cycle counts in converter clocks
  // ----------------------------------------------------------
  localparam logic [4:0] CYCLES_FIRST = 5'd25;
  localparam logic [4:0] CYCLES_NORMAL = 5'd13;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef struct packed {
    logic converterEnable;
    logic conversionStart;
    logic autoTriggerEnable;
    logic completionFlag;
    logic completionIrqEnable;
    logic [2:0] clockPrescalerSelect;
  } acc_ctrl_s;

  typedef struct packed {
    logic [1:0] referenceSelect;
    logic leftAdjustResult;
    logic [4:0] inputChannelSelect;
  } acc_mux_s;

  typedef struct packed {
    logic powered;          // converter powered up
    logic sample;           // one-cycle pulse: conversion begins
    logic initialize;       // this conversion performs initialization
    logic differential;     // result must come as two's complement
    logic [4:0] channel;
    logic [1:0] reference;
  } acc_sar_s;

  typedef enum logic {ACC_IDLE, ACC_CONVERT} acc_conv_e;

endpackage : acc_pkg

// File: rtl/acc_conversion_control.sv
`timescale 1ns/1ns
`default_nettype none

module acc_conversion_control
  import acc_pkg::*;
#(
  parameter int NUM_PINS = 8,      // analog pins with input buffer disable
  parameter int RESULT_W = 10      // conversion result width
)
(
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // processor interrupt side
  input wire logic globalIrqEnable,
  input wire logic irqVectorTaken,
  output logic conversionIrq,
  // trigger flags of other peripherals, codes 1 to 7
  input wire logic [7:1] triggerFlags,
  // analog core
  input wire logic [RESULT_W-1:0] sarResult,
  output acc_sar_s sarControl,
  // analog pins, digital path
  input wire logic [NUM_PINS-1:0] pinRaw,
  output logic [NUM_PINS-1:0] pinInput,
  output logic [NUM_PINS-1:0] pinBufferOn
);

  // ----------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------
  if (RESULT_W != 10)
  begin : gChkWidth
    $error("result width must be 10");
  end
  if (NUM_PINS < 1 || NUM_PINS > 8)
  begin : gChkPins
    $error("pin count must lie in 1..8");
  end

  // ----------------------------------------------------------
  // state registers
  // ----------------------------------------------------------
  acc_ctrl_s ctrl_r;                 // stored control bits (start and flag unused here)
  logic flag_r;                      // completion flag
  logic [2:0] trigSel_r;             // trigger source field
  acc_mux_s mux_r;                   // channel, reference, adjust as written
  logic [7:0] pinDis_r;              // per-pin buffer disable
  logic [RESULT_W-1:0] result_r;     // last stored result
  logic lock_r;                      // low byte read, high byte pending
  acc_conv_e state_r;                // conversion state
  logic [4:0] cycCnt_r;              // converter clocks into conversion
  logic [4:0] cycLen_r;              // length of the running conversion
  logic firstPending_r;              // next conversion is the initializing one
  logic [6:0] prescCnt_r;            // system clock divider
  logic trigPrev_r;                  // selected trigger level, last cycle

  // bus pipeline
  logic busPend_r;                   // data phase waiting for access
  logic busWrite_r;
  logic busMapped_r;
  logic [7:0] busIdx_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;

  // outputs
  logic irq_r;
  acc_sar_s sar_r;
  logic [NUM_PINS-1:0] pinInput_r;
  logic [NUM_PINS-1:0] pinBufferOn_r;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  wire busTake = hsel & htrans[1] & hready & hreadyout_r;
  wire busMapHit = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
  wire busDo = busPend_r & busMapped_r;
  wire busWr = busDo & busWrite_r;
  wire busRd = busDo & ~busWrite_r;
  wire wrCtrl = busWr & (busIdx_r == IDX_CTRL_STATUS);
  wire wrTrig = busWr & (busIdx_r == IDX_TRIG_SELECT);
  wire wrMux = busWr & (busIdx_r == IDX_CHANNEL_SELECT);
  wire wrPin = busWr & (busIdx_r == IDX_PIN_DISABLE);
  wire rdLow = busRd & (busIdx_r == IDX_RESULT_LOW);
  wire rdHigh = busRd & (busIdx_r == IDX_RESULT_HIGH);
  wire acc_ctrl_s ctrlWr = acc_ctrl_s'(hwdata[7:0]);
  wire unusedBus = ^hsize;           // size is not decoded, word access only

  // ----------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------
  // mask of divisor minus one; codes 0 and 1 both divide by two
  function automatic logic [6:0] prescMask(input logic [2:0] code);
    logic [6:0] m;
    m = 7'h01;
    if (code > 3'h1)
    begin
      m = 7'((8'h01 << code) - 8'h01);
    end
    return m;
  endfunction : prescMask

  wire [6:0] divMask = prescMask(ctrl_r.clockPrescalerSelect);
  wire convTick = ctrl_r.converterEnable & ((prescCnt_r & divMask) == divMask);

  // ----------------------------------------------------------
  // enable, trigger and start decisions
  // ----------------------------------------------------------
  wire enNxt = wrCtrl ? ctrlWr.converterEnable : ctrl_r.converterEnable;
  wire enRise = enNxt & ~ctrl_r.converterEnable;
  wire busy = (state_r == ACC_CONVERT);
  wire convDone = busy & convTick & (cycCnt_r == cycLen_r - 5'd1) & enNxt;
  wire abortNow = busy & ~enNxt;

  // selected trigger level, code zero forced low so choosing it makes no edge
  wire [7:0] trigVec = {triggerFlags, 1'b0};
  wire trigLevel = trigVec[trigSel_r];
  wire trigRise = trigLevel & ~trigPrev_r;
  wire autoOn = ctrl_r.autoTriggerEnable & ctrl_r.converterEnable;
  wire freeRun = autoOn & (trigSel_r == TRIG_FREE_RUN);

  wire swStart = wrCtrl & ctrlWr.conversionStart & ctrlWr.converterEnable;
  wire autoStart = autoOn & trigRise;
  wire freeRestart = freeRun & convDone & ~wrCtrl;
  wire startNow = (swStart | autoStart | freeRestart) & enNxt & (~busy | convDone);
  wire firstNow = firstPending_r | enRise;

  // ----------------------------------------------------------
  // result presentation and read data
  // ----------------------------------------------------------
  wire [15:0] resultWord = mux_r.leftAdjustResult ?
    {result_r, {LEFT_PAD{1'b0}}} : {{LEFT_PAD{1'b0}}, result_r};
  wire [7:0] ctrlRead = {ctrl_r.converterEnable, busy, ctrl_r.autoTriggerEnable, flag_r,
    ctrl_r.completionIrqEnable, ctrl_r.clockPrescalerSelect};
  wire [7:0] pinDisRead = pinDis_r;

  logic [7:0] readByte;
  // read multiplexer; unmapped indices read zero
  always_comb
  begin
    unique case (busIdx_r)
      IDX_RESULT_LOW: readByte = resultWord[7:0];
      IDX_RESULT_HIGH: readByte = resultWord[15:8];
      IDX_CTRL_STATUS: readByte = ctrlRead;
      IDX_TRIG_SELECT: readByte = {5'h00, trigSel_r};
      IDX_CHANNEL_SELECT: readByte = mux_r;
      IDX_PIN_DISABLE: readByte = pinDisRead;
      default: readByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------
  // next values
  // ----------------------------------------------------------
  // flag: a completion in the clearing cycle still sets it
  wire flagClr = (wrCtrl & ctrlWr.completionFlag) | irqVectorTaken;
  wire flagNxt = convDone | (flag_r & ~flagClr);

  // channel and reference reach the core only between conversions
  wire acc_mux_s muxNxt = wrMux ? acc_mux_s'(hwdata[7:0]) : mux_r;
  wire holdCfg = busy & ~convDone & ~abortNow;
  wire diffSel = (muxNxt.inputChannelSelect >= DIFF_FIRST) & (muxNxt.inputChannelSelect <= DIFF_LAST);

  // result lock: set by low byte read, released by high byte read
  wire lock_nxt = rdLow | (lock_r & ~rdHigh);

  acc_conv_e state_nxt;
  // conversion state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ACC_IDLE:
      begin
        if (startNow)
        begin
          state_nxt = ACC_CONVERT;
        end
      end
      ACC_CONVERT:
      begin
        if (abortNow)
        begin
          state_nxt = ACC_IDLE;
        end
        else if (convDone & ~startNow)
        begin
          state_nxt = ACC_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------
  // ahb-lite pipeline: one wait state per transfer
  // ----------------------------------------------------------
  // address phase capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busPend_r <= 1'b0;
      busWrite_r <= 1'b0;
      busMapped_r <= 1'b0;
      busIdx_r <= 8'h00;
    end
    else if (busTake)
    begin
      busPend_r <= 1'b1;
      busWrite_r <= hwrite;
      busMapped_r <= busMapHit;
      busIdx_r <= haddr[9:2];
    end
    else
    begin
      busPend_r <= 1'b0;
    end
  end

  // data phase answer; response always okay
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h00000000;
    end
    else
    begin
      hreadyout_r <= ~busTake;
      hresp_r <= 1'b0;
      hrdata_r <= (busPend_r & ~busWrite_r) ? {24'h000000, busMapped_r ? readByte : 8'h00} : hrdata_r;
    end
  end

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  // control, trigger, channel and pin registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r <= acc_ctrl_s'(RST_CTRL_STATUS);
      trigSel_r <= RST_TRIG_SELECT;
      mux_r <= acc_mux_s'(RST_CHANNEL_SELECT);
      pinDis_r <= RST_PIN_DISABLE;
    end
    else
    begin
      ctrl_r <= wrCtrl ? ctrlWr : ctrl_r;
      trigSel_r <= wrTrig ? hwdata[2:0] : trigSel_r;
      mux_r <= muxNxt;
      pinDis_r <= wrPin ? hwdata[7:0] : pinDis_r;
    end
  end

  // completion flag, result, lock and trigger level history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_r <= 1'b0;
      result_r <= RST_RESULT;
      lock_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end
    else
    begin
      flag_r <= flagNxt;
      lock_r <= lock_nxt;
      result_r <= (convDone & ~lock_r) ? sarResult : result_r;
      trigPrev_r <= trigLevel;
    end
  end

  // ----------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------
  // prescaler runs only while enabled, restarting from zero
  always_ff @(posedge clk)
  begin
    if (rst | ~ctrl_r.converterEnable)
    begin
      prescCnt_r <= 7'h00;
    end
    else
    begin
      prescCnt_r <= prescCnt_r + 7'h01;
    end
  end

  // state, cycle counter and length of the running conversion
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ACC_IDLE;
      cycCnt_r <= 5'd0;
      cycLen_r <= CYCLES_NORMAL;
      firstPending_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (startNow)
      begin
        cycCnt_r <= 5'd0;
        cycLen_r <= firstNow ? CYCLES_FIRST : CYCLES_NORMAL;
        firstPending_r <= 1'b0;
      end
      else
      begin
        cycCnt_r <= (busy & convTick) ? cycCnt_r + 5'd1 : cycCnt_r;
        firstPending_r <= firstPending_r | enRise;
      end
    end
  end

  // ----------------------------------------------------------
  // outputs to processor and analog core
  // ----------------------------------------------------------
  // interrupt request and core controls
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      sar_r <= '0;
    end
    else
    begin
      irq_r <= flagNxt & ctrl_r.completionIrqEnable & globalIrqEnable;
      sar_r.powered <= enNxt;
      sar_r.sample <= startNow;
      sar_r.initialize <= startNow ? firstNow : sar_r.initialize;
      sar_r.channel <= holdCfg ? sar_r.channel : muxNxt.inputChannelSelect;
      sar_r.reference <= holdCfg ? sar_r.reference : muxNxt.referenceSelect;
      sar_r.differential <= holdCfg ? sar_r.differential : diffSel;
    end
  end

  // ----------------------------------------------------------
  // per-pin digital input path
  // ----------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : gPin
    logic meta_r;
    logic sync_r;
    // two-stage synchroniser, then gated by the disable bit
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        pinInput_r[i] <= 1'b0;
        pinBufferOn_r[i] <= 1'b1;
      end
      else
      begin
        meta_r <= pinRaw[i];
        sync_r <= meta_r;
        pinInput_r[i] <= sync_r & ~pinDis_r[i];
        pinBufferOn_r[i] <= ~pinDis_r[i];
      end
    end
  end

  // ----------------------------------------------------------
  // output wiring
  // ----------------------------------------------------------
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r | (unusedBus & 1'b0);
  assign hrdata = hrdata_r;
  assign conversionIrq = irq_r;
  assign sarControl = sar_r;
  assign pinInput = pinInput_r;
  assign pinBufferOn = pinBufferOn_r;

endmodule : acc_conversion_control

`default_nettype wire

// File: sim/acc_conversion_control_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker for the conversion control
// ----------------------------------------
module acc_conversion_control_chk
  import acc_pkg::*;
#(
  parameter int NUM_PINS = 8 // analog pins watched
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic globalIrqEnable,
  input wire logic irqVectorTaken,
  input wire logic conversionIrq,
  input wire acc_sar_s sarControl,
  input wire logic [NUM_PINS-1:0] pinInput,
  input wire logic [NUM_PINS-1:0] pinBufferOn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // an address phase the slave accepts
  sequence addrTaken;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  // exactly one wait state, then ready again
  sequence oneWait;
    !hreadyout ##1 hreadyout;
  endsequence
  bus_wait_a: assert property (addrTaken |=> oneWait)
    else $error("bus answer not after one wait state");
  byte_data_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  okay_resp_a: assert property (!hresp)
    else $error("bus response not okay");
  irq_gate_a: assert property (conversionIrq |-> $past(globalIrqEnable))
    else $error("irq without global enable");
  vector_clear_a: assert property (irqVectorTaken |=> !conversionIrq)
    else $error("irq stays after vector taken");
  pin_mask_a: assert property ((pinInput & ~pinBufferOn) == '0)
    else $error("disabled pin reads one");
  sample_pulse_a: assert property (sarControl.sample |-> sarControl.powered ##1 !sarControl.sample)
    else $error("sample not a single pulse while powered");
  first_init_a: assert property ($rose(sarControl.powered) ##[0:1] sarControl.sample |-> sarControl.initialize)
    else $error("first conversion without initialization");
  diff_code_a: assert property (sarControl.sample |-> sarControl.differential ==
    (sarControl.channel >= DIFF_FIRST && sarControl.channel <= DIFF_LAST))
    else $error("differential flag wrong for channel");
  chan_frozen_a: assert property (sarControl.sample |=> $stable(sarControl.channel) [*8])
    else $error("channel changed during conversion");
endmodule : acc_conversion_control_chk

bind acc_conversion_control acc_conversion_control_chk #(.NUM_PINS(NUM_PINS)) chk (.clk, .rst, .hsel, .htrans,
  .hready, .hreadyout, .hresp, .hrdata, .globalIrqEnable, .irqVectorTaken, .conversionIrq, .sarControl,
  .pinInput, .pinBufferOn);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// self-checking bench for conversion control
// ----------------------------------------
module testbench
  import acc_pkg::*;
;
  logic clk, rst, hsel, hwrite, globalIrqEnable, irqVectorTaken;
  logic rdPhase = 1'b0; // a read data phase is pending
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata;
  logic [7:1] triggerFlags;
  logic [9:0] sarResult, lastV, oldV;
  logic [7:0] pinRaw, p, r;
  wire hreadyout, hresp, conversionIrq;
  wire [31:0] hrdata;
  wire acc_sar_s sarControl;
  wire [7:0] pinInput, pinBufferOn;
  int errors = 0, checks_done = 0, samples = 0, s0;
  logic [31:0] expQ[$]; // expected read data, oldest first
  logic [7:0] regs[7] = '{IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CTRL_STATUS, IDX_TRIG_SELECT,
    IDX_CHANNEL_SELECT, IDX_PIN_DISABLE, 8'h7f};

  acc_conversion_control dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .globalIrqEnable, .irqVectorTaken, .conversionIrq,
    .triggerFlags, .sarResult, .sarControl, .pinRaw, .pinInput, .pinBufferOn);

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // comparison, verdict and bus tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // one single transfer: address phase, then data phase, each held until ready
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : xfer

  // write a byte, junk above it
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'($urandom), d});
  endtask : wr

  // read a byte, noting the expected answer
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back({24'h0, exp});
    xfer(idx, 1'b0, $urandom);
  endtask : rd

  // wait for the interrupt, bounded
  task automatic waitIrq(output int n);
    n = 0;
    while (conversionIrq !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000)
      check("irq timeout", 0, 1);
  endtask : waitIrq

  // one software started conversion with interrupt enabled
  task automatic conv(input logic [2:0] ps, input int cyc, input logic [9:0] v);
    int n;
    int dv;
    dv = (ps < 3'h2) ? 2 : (1 << ps);
    sarResult <= v;
    lastV = v;
    wr(IDX_CTRL_STATUS, {5'b11001, ps});
    rd(IDX_CTRL_STATUS, {5'b11001, ps});
    waitIrq(n);
    check("conv cycles", (n + 2 >= cyc * dv - dv) && (n + 2 <= cyc * dv + 3), 1);
    wr(IDX_CTRL_STATUS, {5'b10001, ps});
    rd(IDX_CTRL_STATUS, {5'b10011, ps});
    wr(IDX_CTRL_STATUS, {5'b10011, ps});
    rd(IDX_CTRL_STATUS, {5'b10001, ps});
    check("irq cleared", conversionIrq, 0);
  endtask : conv

  // ----------------------------------------
  // read data monitor and sample counter
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rdPhase && hreadyout === 1'b1)
      check("hrdata", hrdata, expQ.pop_front());
    if (hreadyout === 1'b1)
      rdPhase <= hsel && htrans[1] && !hwrite;
    if (sarControl.sample === 1'b1)
      samples <= samples + 1;
  end

  // watchdog against a hang
  initial
  begin
    #(10 * 40000);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {hsel, hwrite, globalIrqEnable, irqVectorTaken} = 4'h0;
    {htrans, haddr, hwdata, triggerFlags, sarResult, pinRaw} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    void'($urandom(72935));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped index last
    foreach (regs[i]) rd(regs[i], 8'h00);
    // digital input disable
    p = 8'($urandom);
    r = 8'($urandom);
    pinRaw <= p;
    wr(IDX_PIN_DISABLE, r);
    rd(IDX_PIN_DISABLE, r);
    repeat (4) @(posedge clk);
    check("pinBufferOn", pinBufferOn, 8'(~r));
    check("pinInput", pinInput, p & 8'(~r));
    // first conversion, then every prescaler code
    globalIrqEnable <= 1'b1;
    conv(3'h0, 25, 10'($urandom));
    for (int k = 0; k < 8; k++) conv(3'(k), 13, 10'($urandom));
    // presentation, differential channel, read lock
    wr(IDX_CHANNEL_SELECT, 8'h10);
    conv(3'h0, 13, 10'($urandom));
    rd(IDX_RESULT_LOW, lastV[7:0]);
    rd(IDX_RESULT_HIGH, {6'h0, lastV[9:8]});
    wr(IDX_CHANNEL_SELECT, 8'h30);
    rd(IDX_RESULT_LOW, {lastV[1:0], 6'h0});
    rd(IDX_RESULT_HIGH, lastV[9:2]);
    wr(IDX_CHANNEL_SELECT, 8'h10);
    rd(IDX_RESULT_LOW, lastV[7:0]);
    oldV = lastV;
    conv(3'h0, 13, 10'($urandom));
    rd(IDX_RESULT_HIGH, {6'h0, oldV[9:8]});
    conv(3'h0, 13, 10'($urandom));
    rd(IDX_RESULT_LOW, lastV[7:0]);
    rd(IDX_RESULT_HIGH, {6'h0, lastV[9:8]});
    // interrupt gating and vector clear
    globalIrqEnable <= 1'b0;
    wr(IDX_CTRL_STATUS, 8'hc8);
    wr(IDX_CHANNEL_SELECT, 8'h45);
    check("cfg held", {sarControl.reference, sarControl.channel}, 7'h10);
    repeat (40) @(posedge clk);
    check("cfg applied", {sarControl.reference, sarControl.channel}, 7'h25);
    check("irq gated", conversionIrq, 0);
    globalIrqEnable <= 1'b1;
    repeat (2) @(posedge clk);
    check("irq raised", conversionIrq, 1);
    irqVectorTaken <= 1'b1;
    @(posedge clk);
    irqVectorTaken <= 1'b0;
    @(posedge clk);
    check("irq vector", conversionIrq, 0);
    rd(IDX_CTRL_STATUS, 8'h88);
    // abort by disabling, then a fresh first conversion
    wr(IDX_CTRL_STATUS, 8'hc8);
    repeat (3) @(posedge clk);
    wr(IDX_CTRL_STATUS, 8'h00);
    repeat (60) @(posedge clk);
    rd(IDX_CTRL_STATUS, 8'h00);
    check("powered off", sarControl.powered, 0);
    conv(3'h0, 25, 10'($urandom));
    // free running, then switching to it with the flag set
    wr(IDX_TRIG_SELECT, 8'h00);
    s0 = samples;
    wr(IDX_CTRL_STATUS, 8'he0);
    repeat (100) @(posedge clk);
    check("free run", samples - s0 >= 3, 1);
    wr(IDX_TRIG_SELECT, 8'h01);
    repeat (60) @(posedge clk);
    s0 = samples;
    wr(IDX_TRIG_SELECT, 8'h00);
    repeat (40) @(posedge clk);
    check("no free trigger", samples - s0, 0);
    // every trigger source on its rising edge
    for (int k = 1; k < 8; k++)
    begin
      wr(IDX_TRIG_SELECT, 8'(k));
      s0 = samples;
      triggerFlags <= 7'(1 << (k - 1));
      repeat (40) @(posedge clk);
      check("auto trigger", samples - s0, 1);
      triggerFlags <= 7'h00;
    end
    // source ignored without auto trigger, then switch to a set source
    wr(IDX_CTRL_STATUS, 8'h80);
    wr(IDX_TRIG_SELECT, 8'h02);
    s0 = samples;
    triggerFlags <= 7'h02;
    repeat (40) @(posedge clk);
    check("auto off", samples - s0, 0);
    wr(IDX_TRIG_SELECT, 8'h01);
    wr(IDX_CTRL_STATUS, 8'ha0);
    s0 = samples;
    wr(IDX_TRIG_SELECT, 8'h02);
    repeat (40) @(posedge clk);
    check("switch edge", samples - s0, 1);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
